// file: ptb_pkg.sv
package ptb_pkg;

    localparam int          NUM_TRIM      = 5;
    localparam int          ADDR_W        = 12;
    localparam int          STATUS_W      = 4;

    // printed offsets are register indices; byte address is four times the index
    localparam logic [9:0]  IDX_LOAD_OV   = 10'h008;
    localparam logic [9:0]  IDX_LOCAL_UV  = 10'h009;
    localparam logic [9:0]  IDX_LOCAL_OV  = 10'h00a;
    localparam logic [9:0]  IDX_OVERTEMP  = 10'h00b;
    localparam logic [9:0]  IDX_MAINS     = 10'h00c;
    localparam logic [9:0]  IDX_STATUS    = 10'h010;
    localparam logic [9:0]  IDX_MASK      = 10'h011;

    // array slots of the trim bank
    localparam logic [2:0]  SLOT_LOAD_OV  = 3'h0;
    localparam logic [2:0]  SLOT_LOCAL_UV = 3'h1;
    localparam logic [2:0]  SLOT_LOCAL_OV = 3'h2;
    localparam logic [2:0]  SLOT_OVERTEMP = 3'h3;
    localparam logic [2:0]  SLOT_MAINS    = 3'h4;

    // non-volatile shadow of the first trim register
    localparam logic [15:0] NV_BASE       = 16'h8108;

    localparam int          OT_CODE_MSB   = 7;
    localparam int          OT_CODE_LSB   = 4;
    localparam int          SOFT_OT_BIT   = 0;
    localparam int          MAINS_TH_MSB  = 7;
    localparam int          MAINS_TH_LSB  = 3;
    localparam int          MAINS_HY_MSB  = 2;
    localparam int          MAINS_HY_LSB  = 0;

    localparam int          ST_LOAD_DONE  = 0;
    localparam int          ST_HARD_OV    = 1;
    localparam int          ST_SOFT_OT    = 2;
    localparam int          ST_TRIM_WR    = 3;

    localparam logic [7:0]  TRIM_RST      = 8'h00;
    localparam logic [3:0]  STATUS_RST    = 4'h0;
    localparam logic [3:0]  MASK_RST      = 4'h0;

    typedef enum logic [2:0] {
        LD_REQ  = 3'b001,
        LD_WAIT = 3'b010,
        LD_DONE = 3'b100
    } ptb_ld_state_t;

endpackage

// file: ptb_load_if.sv
`timescale 1ns/1ps
interface ptb_load_if;
    logic       wrEn;
    logic [2:0] slot;
    logic [7:0] data;
    logic       done;
    logic       finish;

    modport loader (output wrEn, output slot, output data, output done, output finish);
    modport bank   (input  wrEn, input  slot, input  data, input  done, input  finish);
endinterface

// file: ptb_nv_loader.sv
`timescale 1ns/1ps
module ptb_nv_loader (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    output logic             nvReadReq,
    output logic [15:0]      nvReadAddr,
    input  wire logic [7:0]  nvReadData,
    input  wire logic        nvReadValid,
    ptb_load_if.loader       ld
);

    typedef struct packed {
        ptb_pkg::ptb_ld_state_t state;
        logic [2:0]             slot;
        logic                   wrEn;
        logic [7:0]             data;
        logic                   finish;
    } ptb_ld_reg_t;

    ptb_ld_reg_t st_reg;
    ptb_ld_reg_t st_next;

    always_comb begin
        st_next        = st_reg;
        st_next.wrEn   = 1'b0;
        st_next.finish = 1'b0;
        case (st_reg.state)
            ptb_pkg::LD_REQ: begin
                st_next.state = ptb_pkg::LD_WAIT;
            end
            ptb_pkg::LD_WAIT: begin
                if (nvReadValid) begin
                    st_next.wrEn = 1'b1;
                    st_next.data = nvReadData;
                    if (st_reg.slot == ptb_pkg::SLOT_MAINS) begin
                        st_next.state  = ptb_pkg::LD_DONE;
                        st_next.finish = 1'b1;
                    end else begin
                        st_next.state = ptb_pkg::LD_REQ;
                    end
                end
            end
            ptb_pkg::LD_DONE: begin
                st_next.state = ptb_pkg::LD_DONE;
            end
            default: begin
                st_next.state = ptb_pkg::LD_REQ;
            end
        endcase
        // slot advances after its data has been handed over
        if (st_reg.wrEn && st_reg.state == ptb_pkg::LD_REQ) begin
            st_next.slot = st_reg.slot + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{state: ptb_pkg::LD_REQ, slot: 3'h0, wrEn: 1'b0,
                        data: 8'h00, finish: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign nvReadReq  = (st_reg.state == ptb_pkg::LD_WAIT);
    assign nvReadAddr = ptb_pkg::NV_BASE + {13'h0, st_reg.slot};       // see R1
    assign ld.wrEn    = st_reg.wrEn;
    assign ld.slot    = st_reg.slot;
    assign ld.data    = st_reg.data;
    assign ld.done    = (st_reg.state == ptb_pkg::LD_DONE) && !st_reg.wrEn;
    assign ld.finish  = st_reg.finish;

    a_nv_addr_range: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R1
        nvReadReq |-> (nvReadAddr >= 16'h8108 && nvReadAddr <= 16'h810c))
        else $error("shadow address outside trim range");

endmodule

// file: ptb_trim_bank.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Function
// R1 - after reset each trim register is filled from its matching non-volatile shadow location.
// R2 - the load overvoltage code drives the load overvoltage threshold, code zero at the bottom.
// R3 - the local undervoltage code drives the undervoltage clamp threshold.
// R4 - the local overvoltage code drives the level at which the local overvoltage flag rises.
// R5 - bits 7 to 4 of the overtemperature register form the overtemperature threshold code.
// R6 - bit 0 of the overtemperature register steers fifth monitor overvoltage to soft overtemp.
// R7 - bits 7 to 3 of the mains-sense register select the mains-sense threshold.
// R8 - bits 2 to 0 of the mains-sense register select the mains-sense hysteresis.
// R9 - every bit reads back as last written or loaded, and outputs follow on that write; a mains-sense read stalled by the load returns its pre-load byte.
module ptb_trim_bank (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             nvReadReq,
    output logic [15:0]      nvReadAddr,
    input  wire logic [7:0]  nvReadData,
    input  wire logic        nvReadValid,
    input  wire logic        fifthMonitorOv,
    output logic [7:0]       loadOvCode,
    output logic [7:0]       localUvCode,
    output logic [7:0]       local_overvoltage_code,
    output logic [3:0]       overtempCode,
    output logic             softOtSelect,
    output logic [4:0]       mainsThreshCode,
    output logic [2:0]       mainsHystCode,
    output logic             hardOvFlag,
    output logic             softOtFlag,
    output logic             trimLoaded,
    output logic             irq
);

    typedef struct packed {
        logic [4:0][7:0] trim;
        logic [3:0]      status;
        logic [3:0]      mask;
        logic [31:0]     rdata;
        logic            err;
        logic            monMeta;
        logic            monSync;
        logic            monPrev;
        logic            hardOv;
        logic            softOt;
    } ptb_bank_reg_t;

    ptb_bank_reg_t st_reg;
    ptb_bank_reg_t st_next;

    ptb_load_if ld ();

    ptb_nv_loader u_loader (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .nvReadReq   (nvReadReq),
        .nvReadAddr  (nvReadAddr),
        .nvReadData  (nvReadData),
        .nvReadValid (nvReadValid),
        .ld          (ld.loader)
    );

    logic [9:0] regIdx;
    logic       aligned;
    logic       trimHit;
    logic [2:0] trimSlot;
    logic       statusHit;
    logic       maskHit;
    logic       regHit;
    logic       setupCyc;
    logic       wrAcc;
    logic       monRise;
    logic       softSel;

    assign regIdx    = paddr[11:2];
    assign aligned   = (paddr[1:0] == 2'b00);
    assign trimHit   = aligned && regIdx >= ptb_pkg::IDX_LOAD_OV
                       && regIdx <= ptb_pkg::IDX_MAINS;
    assign trimSlot  = 3'(regIdx - ptb_pkg::IDX_LOAD_OV);
    assign statusHit = aligned && regIdx == ptb_pkg::IDX_STATUS;
    assign maskHit   = aligned && regIdx == ptb_pkg::IDX_MASK;
    assign regHit    = trimHit || statusHit || maskHit;
    assign setupCyc  = psel && !penable;
    // bus stalls until the power-up load has finished
    assign pready    = ld.done;                                          // see R1
    assign wrAcc     = psel && penable && pwrite && pready && regHit;
    assign monRise   = st_reg.monSync && !st_reg.monPrev;
    assign softSel   = st_reg.trim[ptb_pkg::SLOT_OVERTEMP][ptb_pkg::SOFT_OT_BIT];

    always_comb begin
        logic [3:0]  stSet;
        logic [3:0]  stClr;
        logic [31:0] rd;
        stSet        = 4'h0;
        stClr        = 4'h0;
        rd           = 32'h0000_0000;
        st_next      = st_reg;
        st_next.monMeta = fifthMonitorOv;
        st_next.monSync = st_reg.monMeta;
        st_next.monPrev = st_reg.monSync;
        // positive overvoltage of the fifth monitor is reported one way or the other
        st_next.hardOv  = st_reg.monSync && !softSel;                    // see R6
        st_next.softOt  = st_reg.monSync && softSel;                     // see R6
        if (ld.wrEn) begin
            st_next.trim[ld.slot] = ld.data;                             // see R1
        end
        if (wrAcc && trimHit) begin
            st_next.trim[trimSlot] = pwdata[7:0];                        // see R9
            stSet[ptb_pkg::ST_TRIM_WR] = 1'b1;
        end
        if (wrAcc && maskHit) begin
            st_next.mask = pwdata[3:0];
        end
        if (wrAcc && statusHit) begin
            stClr = pwdata[3:0];
        end
        stSet[ptb_pkg::ST_LOAD_DONE] = ld.finish;
        stSet[ptb_pkg::ST_HARD_OV]   = monRise && !softSel;
        stSet[ptb_pkg::ST_SOFT_OT]   = monRise && softSel;
        // a new event wins over a clear in the same cycle
        st_next.status = (st_reg.status & ~stClr) | stSet;
        if (trimHit) begin
            rd = {24'h000000, st_reg.trim[trimSlot]};                    // see R9
        end else if (statusHit) begin
            rd = {28'h0000000, st_reg.status};
        end else if (maskHit) begin
            rd = {28'h0000000, st_reg.mask};
        end
        // keep sampling through a stall so a read issued during the load sees loaded data, except mains-sense, which returns its pre-load byte
        if (setupCyc || (psel && penable && !pready)) begin
            st_next.rdata = pwrite ? 32'h0000_0000 : rd;
            st_next.err   = !regHit;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{trim: {5{ptb_pkg::TRIM_RST}}, status: ptb_pkg::STATUS_RST,
                        mask: ptb_pkg::MASK_RST, rdata: 32'h0000_0000, err: 1'b0,
                        monMeta: 1'b0, monSync: 1'b0, monPrev: 1'b0,
                        hardOv: 1'b0, softOt: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata                 = st_reg.rdata;
    assign pslverr                = st_reg.err && psel && penable;
    assign loadOvCode             = st_reg.trim[ptb_pkg::SLOT_LOAD_OV];  // see R2
    assign localUvCode            = st_reg.trim[ptb_pkg::SLOT_LOCAL_UV]; // see R3
    assign local_overvoltage_code = st_reg.trim[ptb_pkg::SLOT_LOCAL_OV]; // see R4
    assign overtempCode           = st_reg.trim[ptb_pkg::SLOT_OVERTEMP]
                                    [ptb_pkg::OT_CODE_MSB:ptb_pkg::OT_CODE_LSB]; // see R5
    assign softOtSelect           = softSel;                             // see R6
    assign mainsThreshCode        = st_reg.trim[ptb_pkg::SLOT_MAINS]
                                    [ptb_pkg::MAINS_TH_MSB:ptb_pkg::MAINS_TH_LSB]; // see R7
    assign mainsHystCode          = st_reg.trim[ptb_pkg::SLOT_MAINS]
                                    [ptb_pkg::MAINS_HY_MSB:ptb_pkg::MAINS_HY_LSB]; // see R8
    assign hardOvFlag             = st_reg.hardOv;
    assign softOtFlag             = st_reg.softOt;
    assign trimLoaded             = ld.done;
    assign irq                    = |(st_reg.status & st_reg.mask);

    a_load_fills_slot: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R1
        (ld.wrEn && ld.slot == 3'h0) |=> (loadOvCode == $past(ld.data)))
        else $error("loaded value not placed in load overvoltage trim");

    a_load_ov_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R2
        (wrAcc && regIdx == 10'h008) |=> (loadOvCode == $past(pwdata[7:0])))
        else $error("load overvoltage code not updated by write");

    a_local_uv_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R3
        (wrAcc && regIdx == 10'h009) |=> (localUvCode == $past(pwdata[7:0])))
        else $error("local undervoltage code not updated by write");

    a_local_ov_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R4
        (wrAcc && regIdx == 10'h00a) |=> (local_overvoltage_code == $past(pwdata[7:0])))
        else $error("local overvoltage code not updated by write");

    a_overtemp_fields: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R5
        (wrAcc && regIdx == 10'h00b) |=>
            (overtempCode == $past(pwdata[7:4]) && softOtSelect == $past(pwdata[0])))
        else $error("overtemperature code or select wrong after write");

    a_soft_ot_steer: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R6
        $rose(st_reg.monSync) |-> ##1 (softOtFlag == $past(softSel) && hardOvFlag != softOtFlag))
        else $error("fifth monitor result steered wrongly");

    a_mains_thresh: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R7
        (wrAcc && regIdx == 10'h00c) |=> (mainsThreshCode == $past(pwdata[7:3])))
        else $error("mains-sense threshold code wrong after write");

    a_mains_hyst: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R8
        (wrAcc && regIdx == 10'h00c) |=> (mainsHystCode == $past(pwdata[2:0])))
        else $error("mains-sense hysteresis code wrong after write");

    a_read_back_trim: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R9
        (setupCyc && !pwrite && aligned && regIdx == ptb_pkg::IDX_OVERTEMP)
            ##1 (penable && pready)
            |-> (prdata == {24'h000000, $past(st_reg.trim[ptb_pkg::SLOT_OVERTEMP])}))
        else $error("trim read-back differs from stored value");

    a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_reg.status[ptb_pkg::ST_HARD_OV] && st_reg.mask[ptb_pkg::ST_HARD_OV]) |-> irq)
        else $error("interrupt low with unmasked event pending");

    a_load_done_flag: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R1
        $rose(ld.done) |-> st_reg.status[ptb_pkg::ST_LOAD_DONE])
        else $error("load done status missing when bus is released");

    a_trim_wr_flag: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R9
        (wrAcc && trimHit) |=> st_reg.status[ptb_pkg::ST_TRIM_WR])
        else $error("trim write did not set its status bit");

    a_event_sets: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R6
        (monRise && !softSel) |=> st_reg.status[ptb_pkg::ST_HARD_OV])
        else $error("hard overvoltage event lost");

    a_status_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wrAcc && statusHit && pwdata[ptb_pkg::ST_HARD_OV] && !monRise)
            |=> !st_reg.status[ptb_pkg::ST_HARD_OV])
        else $error("write of one did not clear status bit");

    a_unmapped_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (setupCyc && !regHit) ##1 (psel && penable) |-> (pslverr && prdata == 32'h0000_0000))
        else $error("unmapped access not answered with error");

    a_unmapped_nowr: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R9
        (psel && penable && pready && pwrite && !regHit) |=> $stable(st_reg.trim))
        else $error("unmapped write changed a trim register");

endmodule

// file: ptb_trim_bank_tb.sv
`timescale 1ns/1ps
module ptb_trim_bank_tb;
    logic        sys_clk        = 1'b0;
    logic        rst_n          = 1'b0;
    logic        psel           = 1'b0;
    logic        penable        = 1'b0;
    logic        pwrite         = 1'b0;
    logic [11:0] paddr          = 12'h000;
    logic [31:0] pwdata         = 32'h0;
    logic [7:0]  nvReadData     = 8'h00;
    logic        nvReadValid    = 1'b0;
    logic        fifthMonitorOv = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        nvReadReq;
    logic [15:0] nvReadAddr;
    logic [7:0]  loadOvCode;
    logic [7:0]  localUvCode;
    logic [7:0]  local_overvoltage_code;
    logic [3:0]  overtempCode;
    logic        softOtSelect;
    logic [4:0]  mainsThreshCode;
    logic [2:0]  mainsHystCode;
    logic        hardOvFlag;
    logic        softOtFlag;
    logic        trimLoaded;
    logic        irq;
    int          errors         = 0;
    int          compares       = 0;
    logic [32:0] expQ[$];
    logic [7:0]  trim[5];

    always #2.5 sys_clk = ~sys_clk;

    ptb_trim_bank DUT (
        .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .nvReadReq, .nvReadAddr, .nvReadData, .nvReadValid, .fifthMonitorOv,
        .loadOvCode, .localUvCode, .local_overvoltage_code, .overtempCode, .softOtSelect,
        .mainsThreshCode, .mainsHystCode, .hardOvFlag, .softOtFlag, .trimLoaded, .irq
    );

    task automatic report_and_stop;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // completed reads: {pslverr, prdata} against the oldest note
    always @(posedge sys_clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (expQ.size() == 0) begin
                errors++;
                $display("FAIL t=%0t seen=%h exp=%h", $time, prdata, 32'h0);
            end else begin
                check({pslverr, prdata}, expQ.pop_front());
            end
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        if (!wr) begin
            expQ.push_back(e);
        end
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // pready read at each rising edge; request held until it is seen high
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        if (pready !== 1'b1) begin
            errors++;
            report_and_stop();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic shadow_load;
        int n;
        for (int i = 0; i < 5; i++) begin
            n = 0;
            while (nvReadReq !== 1'b1 && n < 100) begin
                @(posedge sys_clk);
                n++;
            end
            if (nvReadReq !== 1'b1) begin
                errors++;
                report_and_stop();
            end
            check({17'h0, nvReadAddr}, {17'h0, ptb_pkg::NV_BASE + 16'(i)});
            repeat ($urandom_range(3)) @(posedge sys_clk);
            nvReadValid <= 1'b1;
            nvReadData  <= trim[i];
            @(posedge sys_clk);
            nvReadValid <= 1'b0;
            nvReadData  <= ~trim[i];
            @(posedge sys_clk);
        end
    endtask

    task automatic chk_codes;
        @(negedge sys_clk);
        check(33'(loadOvCode), 33'(trim[0]));
        check(33'(localUvCode), 33'(trim[1]));
        check(33'(local_overvoltage_code), 33'(trim[2]));
        check(33'(overtempCode), 33'(trim[3][7:4]));
        check(33'(softOtSelect), 33'(trim[3][0]));
        check(33'(mainsThreshCode), 33'(trim[4][7:3]));
        check(33'(mainsHystCode), 33'(trim[4][2:0]));
    endtask

    task automatic read_all;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'h020 + 12'(4 * i), 32'h0, {9'h0, 16'h0, trim[i]});
        end
    endtask

    initial begin
        void'($urandom(32'h91765625));
        foreach (trim[i]) trim[i] = 8'($urandom);
        repeat (12) @(posedge sys_clk);
        check(33'(pready), 33'h0);
        check(33'(trimLoaded), 33'h0);
        rst_n <= 1'b1;
        // a read issued during the power-up load stalls, then sees the loaded byte
        fork
            shadow_load();
            apb(1'b0, 12'h020, 32'h0, {9'h0, 16'h0, trim[0]});
        join
        chk_codes();
        check(33'(trimLoaded), 33'h1);
        read_all();
        apb(1'b0, 12'h040, 32'h0, 33'h1);
        for (int i = 0; i < 5; i++) begin
            trim[i] = 8'($urandom);
            apb(1'b1, 12'h020 + 12'(4 * i), {24'($urandom), trim[i]}, 33'h0);
            chk_codes();
        end
        read_all();
        apb(1'b0, 12'h0fc, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 12'h021, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h0fc, 32'hff, 33'h0);
        read_all();
        apb(1'b0, 12'h040, 32'h0, 33'h9);
        apb(1'b1, 12'h040, 32'hf, 33'h0);
        apb(1'b0, 12'h040, 32'h0, 33'h0);
        apb(1'b1, 12'h044, 32'hf, 33'h0);
        for (int s = 0; s < 2; s++) begin
            trim[3][0] = 1'(s);
            apb(1'b1, 12'h02c, {24'h0, trim[3]}, 33'h0);
            apb(1'b1, 12'h040, 32'hf, 33'h0);
            fifthMonitorOv <= 1'b1;
            repeat (5) @(posedge sys_clk);
            @(negedge sys_clk);
            check(33'(hardOvFlag), 33'(s == 0));
            check(33'(softOtFlag), 33'(s == 1));
            check(33'(irq), 33'h1);
            apb(1'b0, 12'h040, 32'h0, (s == 1) ? 33'h4 : 33'h2);
            apb(1'b1, 12'h044, 32'h0, 33'h0);
            @(negedge sys_clk);
            check(33'(irq), 33'h0);
            apb(1'b1, 12'h044, 32'hf, 33'h0);
            apb(1'b1, 12'h040, 32'hf, 33'h0);
            @(negedge sys_clk);
            check(33'(irq), 33'h0);
            @(posedge sys_clk);
            fifthMonitorOv <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        report_and_stop();
    end
endmodule
